// ==== faso_pkg.sv ====
// package: register map, field layout and timing constants of the fault alarm / signal loss outputs
package faso_pkg;

	// ****************************************************************
	// register byte offsets
	// ****************************************************************
	localparam logic [7:0] OFS_CTRL = 8'h00;     // relay polarity, routing, function codes
	localparam logic [7:0] OFS_STAT = 8'h04;     // live state (read only)
	localparam logic [7:0] OFS_START = 8'h08;    // start frequency adjust threshold
	localparam logic [7:0] OFS_VREF = 8'h0c;     // voltage reference reading (read only)
	localparam logic [7:0] OFS_IREF = 8'h10;     // current reference reading (read only)
	localparam logic [7:0] OFS_IRQ_STAT = 8'h14; // sticky events, write one to clear
	localparam logic [7:0] OFS_IRQ_MASK = 8'h18; // interrupt enables

	// ****************************************************************
	// control register fields
	// ****************************************************************
	localparam int CTRL_POL_BIT = 0;       // 1 = normally closed relay
	localparam int CTRL_SRC_LO = 8;        // frequency source select
	localparam int CTRL_OC_FN_LO = 16;     // open-collector function code
	localparam int CTRL_RLY_FN_LO = 24;    // relay function code
	localparam logic [31:0] CTRL_RESET = 32'h0505_0101;

	// ****************************************************************
	// function codes and thresholds
	// ****************************************************************
	localparam logic [7:0] FN_ALARM = 8'h05;     // fault alarm flag
	localparam logic [7:0] FN_LOSS = 8'h06;      // analog loss flag
	localparam logic [7:0] SRC_TERMINAL = 8'h01; // reference from analog terminals
	localparam int IREF_UA_PER_LSB = 10;         // current reading scale, microamps per count
	localparam int IREF_FLOOR_UA = 4000;         // 4 mA floor
	localparam logic [11:0] IREF_FLOOR = 12'(IREF_FLOOR_UA / IREF_UA_PER_LSB);
	localparam logic [11:0] START_RESET = 12'h000;

	// ****************************************************************
	// timing
	// ****************************************************************
	localparam int CLK_HZ = 125_000_000;
	localparam int ENERGIZE_DELAY_MS = 1000;  // below the 2 s ceiling
	localparam int ENERGIZE_CYCLES = ENERGIZE_DELAY_MS * (CLK_HZ / 1000);

	// ****************************************************************
	// status / interrupt bits
	// ****************************************************************
	localparam int EV_TRIP = 0;   // trip entered
	localparam int EV_CLEAR = 1;  // fault cleared
	localparam int EV_LOSS = 2;   // analog loss rose
	localparam int EV_REGAIN = 3; // analog loss fell
	localparam int EV_N = 4;

	// relay drive outputs travel together
	typedef struct packed {
		logic coil;      // relay coil energized
		logic contact_a; // common closed to contact a
		logic contact_b; // common closed to contact b
	} faso_relay_t;

endpackage : faso_pkg

// ==== faso_top.sv ====
// module: fault alarm flag, relay drive and analog loss flag with an axi4-lite register slave
`timescale 1ns/100ps
`default_nettype none

module faso_top #(
	parameter int ENERGIZE_CYCLES = faso_pkg::ENERGIZE_CYCLES, // shorten in simulation
	parameter int REF_W = 12                                   // analog reading width
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// drive state (from the drive's own logic, same clock)
	input wire logic trip_state_in,
	input wire logic [REF_W-1:0] voltage_ref_in,
	input wire logic [REF_W-1:0] current_reference_input_in,
	input wire logic current_mode_in,
	// axi4-lite write address
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [7:0] s_axi_awaddr,
	// axi4-lite write data
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	// axi4-lite write response
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	// axi4-lite read
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [7:0] s_axi_araddr,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	// outputs
	output logic fault_alarm_flag_out,
	output logic analog_loss_flag_out,
	output logic open_collector_out,
	output faso_pkg::faso_relay_t relay_out,
	output logic irq_out
);

	// ****************************************************************
	// helpers
	// ****************************************************************

	// resolve a function code to its flag; unknown codes give off
	function automatic logic fn_value(input logic [7:0] code, input logic alarm, input logic loss);
		logic v;
		v = 1'b0;
		if (code == faso_pkg::FN_ALARM) begin
			v = alarm;
		end else if (code == faso_pkg::FN_LOSS) begin
			v = loss;
		end
		return v;
	endfunction : fn_value

	// byte-lane merge for register writes
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] st);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (st[i]) begin
				r[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return merge_ret(r);
	endfunction : merge

	function automatic logic [31:0] merge_ret(input logic [31:0] r);
		return r;
	endfunction : merge_ret

	localparam int CNT_W = $clog2(ENERGIZE_CYCLES + 1);

	// ****************************************************************
	// state
	// ****************************************************************
	logic [31:0] ctrl_q, ctrl_d;          // control register
	logic [REF_W-1:0] start_q, start_d;   // start frequency adjust
	logic [faso_pkg::EV_N-1:0] ist_q, ist_d; // sticky events
	logic [faso_pkg::EV_N-1:0] imask_q, imask_d; // interrupt mask
	logic alarm_q, alarm_d;               // registered fault alarm flag
	logic loss_q, loss_d;                 // registered analog loss flag
	logic oc_q, oc_d;                     // open-collector drive
	faso_pkg::faso_relay_t relay_q, relay_d;
	logic irq_q, irq_d;
	logic [CNT_W-1:0] pwr_cnt_q, pwr_cnt_d; // power-up energize delay
	logic pwr_ok_q, pwr_ok_d;             // delay elapsed
	// bus state
	logic aw_q, aw_d;                     // write address held
	logic w_q, w_d;                       // write data held
	logic [7:0] awaddr_q, awaddr_d;
	logic [31:0] wdata_q, wdata_d;
	logic [3:0] wstrb_q, wstrb_d;
	logic bvalid_q, bvalid_d;
	logic [1:0] bresp_q, bresp_d;
	logic rvalid_q, rvalid_d;
	logic [31:0] rdata_q, rdata_d;
	logic [1:0] rresp_q, rresp_d;

	// ****************************************************************
	// flag logic
	// ****************************************************************
	logic loss_now;  // combinational loss detect
	logic polarity_nc;
	logic relay_fn;
	logic do_write;
	logic [faso_pkg::EV_N-1:0] ev;

	// loss detection is pure compare: nothing latches, nothing trips
	always_comb begin
		polarity_nc = ctrl_q[faso_pkg::CTRL_POL_BIT];
		loss_now = 1'b0;
		if (ctrl_q[faso_pkg::CTRL_SRC_LO +: 8] == faso_pkg::SRC_TERMINAL) begin
			if (current_mode_in) begin
				// 4-20 mA range, below the floor is loss
				loss_now = current_reference_input_in < REF_W'(faso_pkg::IREF_FLOOR);
			end else begin
				loss_now = voltage_ref_in < start_q;
			end
		end
		// flags follow their sources, so clearing the fault clears the flag
		alarm_d = trip_state_in;
		loss_d = loss_now;
		relay_fn = fn_value(ctrl_q[faso_pkg::CTRL_RLY_FN_LO +: 8], alarm_q, loss_q);
		oc_d = fn_value(ctrl_q[faso_pkg::CTRL_OC_FN_LO +: 8], alarm_q, loss_q);
		// power-up hold-off before a normally closed relay may pull in
		pwr_cnt_d = pwr_cnt_q;
		pwr_ok_d = pwr_ok_q;
		if (!pwr_ok_q) begin
			if (pwr_cnt_q == CNT_W'(ENERGIZE_CYCLES - 1)) begin
				pwr_ok_d = 1'b1;
			end else begin
				pwr_cnt_d = pwr_cnt_q + CNT_W'(1);
			end
		end
		if (polarity_nc) begin
			// coil held in while healthy; trip or lost supply drops it
			relay_d.coil = pwr_ok_q && !relay_fn;
		end else begin
			// coil pulls in only on the event; lost supply shows nothing
			relay_d.coil = relay_fn;
		end
		relay_d.contact_a = relay_d.coil;
		relay_d.contact_b = !relay_d.coil;
	end

	// ****************************************************************
	// register file and interrupts
	// ****************************************************************
	always_comb begin
		ev[faso_pkg::EV_TRIP] = alarm_d && !alarm_q;
		ev[faso_pkg::EV_CLEAR] = !alarm_d && alarm_q;
		ev[faso_pkg::EV_LOSS] = loss_d && !loss_q;
		ev[faso_pkg::EV_REGAIN] = !loss_d && loss_q;
		do_write = aw_q && w_q && !bvalid_q;
		ctrl_d = ctrl_q;
		start_d = start_q;
		imask_d = imask_q;
		ist_d = ist_q;
		bresp_d = bresp_q;
		if (do_write) begin
			bresp_d = 2'h0;
			case (awaddr_q)
				faso_pkg::OFS_CTRL: ctrl_d = merge(ctrl_q, wdata_q, wstrb_q);
				faso_pkg::OFS_START: start_d = REF_W'(merge(32'(start_q), wdata_q, wstrb_q));
				faso_pkg::OFS_IRQ_MASK: imask_d = faso_pkg::EV_N'(merge(32'(imask_q), wdata_q, wstrb_q));
				faso_pkg::OFS_IRQ_STAT: begin
					if (wstrb_q[0]) begin
						ist_d = ist_q & ~wdata_q[faso_pkg::EV_N-1:0];
					end
				end
				faso_pkg::OFS_STAT, faso_pkg::OFS_VREF, faso_pkg::OFS_IREF: begin
					bresp_d = 2'h0; // read-only, write ignored
				end
				default: bresp_d = 2'h3; // unmapped
			endcase
		end
		// set wins over a same-cycle clear
		ist_d = ist_d | ev;
		irq_d = |(ist_q & imask_q);
	end

	// ****************************************************************
	// axi4-lite channel handling
	// ****************************************************************
	always_comb begin
		aw_d = aw_q;
		w_d = w_q;
		awaddr_d = awaddr_q;
		wdata_d = wdata_q;
		wstrb_d = wstrb_q;
		bvalid_d = bvalid_q;
		rvalid_d = rvalid_q;
		rdata_d = rdata_q;
		rresp_d = rresp_q;
		// address and data captured independently, one each
		if (s_axi_awvalid && !aw_q) begin
			aw_d = 1'b1;
			awaddr_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && !w_q) begin
			w_d = 1'b1;
			wdata_d = s_axi_wdata;
			wstrb_d = s_axi_wstrb;
		end
		if (do_write) begin
			bvalid_d = 1'b1;
		end
		if (bvalid_q && s_axi_bready) begin
			bvalid_d = 1'b0;
			aw_d = 1'b0;
			w_d = 1'b0;
		end
		if (rvalid_q && s_axi_rready) begin
			rvalid_d = 1'b0;
		end else if (s_axi_arvalid && !rvalid_q) begin
			rvalid_d = 1'b1;
			rresp_d = 2'h0;
			case (s_axi_araddr)
				faso_pkg::OFS_CTRL: rdata_d = ctrl_q;
				faso_pkg::OFS_STAT: rdata_d = {27'h0, pwr_ok_q, relay_q.coil, oc_q, loss_q, alarm_q};
				faso_pkg::OFS_START: rdata_d = 32'(start_q);
				faso_pkg::OFS_VREF: rdata_d = 32'(voltage_ref_in);
				faso_pkg::OFS_IREF: rdata_d = 32'(current_reference_input_in);
				faso_pkg::OFS_IRQ_STAT: rdata_d = 32'(ist_q);
				faso_pkg::OFS_IRQ_MASK: rdata_d = 32'(imask_q);
				default: begin
					rdata_d = 32'h0;
					rresp_d = 2'h3;
				end
			endcase
		end
	end

	// ****************************************************************
	// registers
	// ****************************************************************
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ctrl_q <= faso_pkg::CTRL_RESET;
			start_q <= REF_W'(faso_pkg::START_RESET);
			ist_q <= '0;
			imask_q <= '0;
			alarm_q <= 1'b0;
			loss_q <= 1'b0;
			oc_q <= 1'b0;
			relay_q <= '{coil: 1'b0, contact_a: 1'b0, contact_b: 1'b1};
			irq_q <= 1'b0;
			pwr_cnt_q <= '0;
			pwr_ok_q <= 1'b0;
			aw_q <= 1'b0;
			w_q <= 1'b0;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h0;
			wstrb_q <= 4'h0;
			bvalid_q <= 1'b0;
			bresp_q <= 2'h0;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0;
			rresp_q <= 2'h0;
		end else begin
			ctrl_q <= ctrl_d;
			start_q <= start_d;
			ist_q <= ist_d;
			imask_q <= imask_d;
			alarm_q <= alarm_d;
			loss_q <= loss_d;
			oc_q <= oc_d;
			relay_q <= relay_d;
			irq_q <= irq_d;
			pwr_cnt_q <= pwr_cnt_d;
			pwr_ok_q <= pwr_ok_d;
			aw_q <= aw_d;
			w_q <= w_d;
			awaddr_q <= awaddr_d;
			wdata_q <= wdata_d;
			wstrb_q <= wstrb_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			rvalid_q <= rvalid_d;
			rdata_q <= rdata_d;
			rresp_q <= rresp_d;
		end
	end

	// ****************************************************************
	// outputs, all from flip-flops; the three ready outputs through an inverter
	// ****************************************************************
	assign fault_alarm_flag_out = alarm_q;
	assign analog_loss_flag_out = loss_q;
	assign open_collector_out = oc_q;
	assign relay_out = relay_q;
	assign irq_out = irq_q;
	assign s_axi_awready = !aw_q;
	assign s_axi_wready = !w_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = !rvalid_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;

endmodule : faso_top
`default_nettype wire

// ==== faso_asserts.sv ====
// checker: port-level assertions for the fault alarm and signal loss outputs
`timescale 1ns/100ps
`default_nettype none
module faso_asserts #(
	parameter int ENERGIZE_CYCLES = 16,
	parameter int REF_W = 12
) (
	// clock, reset and drive state
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic trip_state_in,
	input wire logic [REF_W-1:0] current_reference_input_in,
	input wire logic current_mode_in,
	// read handshake
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	// flags and relay
	input wire logic fault_alarm_flag_out,
	input wire logic analog_loss_flag_out,
	input wire faso_pkg::faso_relay_t relay_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	// ****************************************************************
	// edges since reset release, saturating so it cannot wrap
	// ****************************************************************
	int up_q;
	int up_d;
	always_comb begin
		up_d = (up_q < ENERGIZE_CYCLES) ? up_q + 1 : up_q;
	end
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			up_q <= 0;
		end else begin
			up_q <= up_d;
		end
	end
	// ****************************************************************
	// properties
	// ****************************************************************
	property p_alarm_on;
		trip_state_in |=> fault_alarm_flag_out;
	endproperty
	a_alarm_on: assert property (p_alarm_on) else $error("alarm flag missing in trip");
	property p_alarm_off;
		!trip_state_in |=> !fault_alarm_flag_out;
	endproperty
	a_alarm_off: assert property (p_alarm_off) else $error("alarm flag without trip");
	property p_powerup;
		up_q < ENERGIZE_CYCLES |-> !relay_out.coil;
	endproperty
	a_powerup: assert property (p_powerup) else $error("coil energized too early");
	property p_contacts;
		relay_out.contact_a == relay_out.coil && relay_out.contact_b == !relay_out.coil;
	endproperty
	a_contacts: assert property (p_contacts) else $error("contacts disagree with coil");
	property p_cur_low;
		current_mode_in && current_reference_input_in < faso_pkg::IREF_FLOOR |=> analog_loss_flag_out;
	endproperty
	a_cur_low: assert property (p_cur_low) else $error("current loss not flagged");
	property p_cur_ok;
		current_mode_in && current_reference_input_in >= faso_pkg::IREF_FLOOR |=> !analog_loss_flag_out;
	endproperty
	a_cur_ok: assert property (p_cur_ok) else $error("loss flag stuck with current ok");
	property p_no_trip;
		$rose(analog_loss_flag_out) && !trip_state_in |=> !fault_alarm_flag_out;
	endproperty
	a_no_trip: assert property (p_no_trip) else $error("signal loss raised alarm");
	property p_rd_answer;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
endmodule : faso_asserts
bind faso_top faso_asserts #(.ENERGIZE_CYCLES(ENERGIZE_CYCLES), .REF_W(REF_W)) faso_asserts_i (.clk_in(clk_in),
	.rst_n_in(rst_n_in), .trip_state_in(trip_state_in), .current_reference_input_in(current_reference_input_in),
	.current_mode_in(current_mode_in), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid), .fault_alarm_flag_out(fault_alarm_flag_out),
	.analog_loss_flag_out(analog_loss_flag_out), .relay_out(relay_out));
`default_nettype wire

// ==== faso_ref_model.sv ====
// partner model: analog reference source and external alarm loop on the relay contacts
`timescale 1ns/100ps
`default_nettype none
module faso_ref_model (
	// relay contacts from the block
	input wire faso_pkg::faso_relay_t relay_in,
	// analog reference toward the block
	output logic [11:0] voltage_ref_out,
	output logic [11:0] current_ref_out,
	output logic current_mode_out,
	// high while the loop is closed, i.e. no alarm
	output logic loop_closed_out
);
	logic nc_wiring_q = 1'b1; // loop wired on contact a (nc) or contact b (no)
	initial begin
		voltage_ref_out = 12'hfff;
		current_ref_out = 12'h3e8;
		current_mode_out = 1'b0;
	end
	// new reference values, applied right after a clock edge
	task automatic set_ref(input logic [11:0] v, input logic [11:0] i, input logic m);
		voltage_ref_out <= v;
		current_ref_out <= i;
		current_mode_out <= m;
	endtask : set_ref
	task automatic set_wiring(input logic nc);
		nc_wiring_q <= nc;
	endtask : set_wiring
	// on nc wiring a broken coil drive reads as an open loop, the safe side; on no wiring it reads as closed
	assign loop_closed_out = nc_wiring_q ? relay_in.contact_a : relay_in.contact_b;
endmodule : faso_ref_model
`default_nettype wire

// ==== testbench.sv ====
// testbench: bus-driven scenarios for the fault alarm and signal loss outputs
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
	$display("Error %s exp %0h got %0h", nm, e, g); end end
module testbench;
	localparam int EC = 16; // shortened power-up delay
	logic clk_in, rst_n_in, trip_state_in, current_mode_in;
	logic [11:0] voltage_ref_in, current_reference_input_in;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	logic fault_alarm_flag_out, analog_loss_flag_out, open_collector_out, irq_out, loop_closed;
	faso_pkg::faso_relay_t relay_out;
	int error_cnt = 0;
	int n_checks = 0;
	faso_top #(.ENERGIZE_CYCLES(EC), .REF_W(12)) faso_top_i (.clk_in, .rst_n_in, .trip_state_in, .voltage_ref_in,
		.current_reference_input_in, .current_mode_in, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
		.s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
		.s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
		.s_axi_rresp, .fault_alarm_flag_out, .analog_loss_flag_out, .open_collector_out, .relay_out, .irq_out);
	faso_ref_model faso_ref_model_i (.relay_in(relay_out), .voltage_ref_out(voltage_ref_in),
		.current_ref_out(current_reference_input_in), .current_mode_out(current_mode_in),
		.loop_closed_out(loop_closed));
	initial begin
		clk_in = 1'b0;
		forever #4 clk_in = ~clk_in;
	end
	task automatic finish_test;
		if (error_cnt == 0 && n_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : finish_test
	// n edges, then settle past the edge
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask : cyc
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		int i;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (i = 0; i < 64; i++) begin
			@(posedge clk_in);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		rs = s_axi_bresp;
		s_axi_bready <= 1'b0;
		if (i == 64) begin
			error_cnt++;
			finish_test();
		end
	endtask : axi_wr
	task automatic axi_rd(input logic [7:0] a);
		int i;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (i = 0; i < 64; i++) begin
			@(posedge clk_in);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		rd = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 1'b0;
		if (i == 64) begin
			error_cnt++;
			finish_test();
		end
	endtask : axi_rd
	// ****************************************************************
	// scenarios
	// ****************************************************************
	initial begin
		{rst_n_in, trip_state_in, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hf;
		repeat (2) @(posedge clk_in);
		rst_n_in <= 1'b1;
		cyc(1);
		`CHK("coil", 1'b0, relay_out.coil)
		axi_rd(faso_pkg::OFS_CTRL);
		`CHK("ctrl", faso_pkg::CTRL_RESET, rd)
		axi_rd(8'h1c);
		`CHK("rresp", 2'h3, rs)
		`CHK("rdata", 32'h0, rd)
		// unmapped write is answered with a decode error and changes nothing
		axi_wr(8'h1c, 32'h0000_0000);
		`CHK("bresp", 2'h3, rs)
		cyc(EC);
		`CHK("coil", 1'b1, relay_out.coil)
		`CHK("loop", 1'b1, loop_closed)
		// live state: delay elapsed, coil in, no flags
		axi_rd(faso_pkg::OFS_STAT);
		`CHK("stat", 32'h0000_0018, rd)
		// trip with interrupt enabled, nc polarity
		axi_wr(faso_pkg::OFS_IRQ_MASK, 32'h0000_0001);
		`CHK("bresp", 2'h0, rs)
		trip_state_in <= 1'b1;
		cyc(2);
		`CHK("alarm", 1'b1, fault_alarm_flag_out)
		`CHK("oc", 1'b1, open_collector_out)
		`CHK("loop", 1'b0, loop_closed)
		cyc(1);
		`CHK("irq", 1'b1, irq_out)
		axi_wr(faso_pkg::OFS_IRQ_STAT, 32'h0000_0001);
		cyc(2);
		`CHK("irq", 1'b0, irq_out)
		trip_state_in <= 1'b0;
		cyc(2);
		`CHK("alarm", 1'b0, fault_alarm_flag_out)
		// normally open polarity
		axi_wr(faso_pkg::OFS_CTRL, 32'h0505_0100);
		faso_ref_model_i.set_wiring(1'b0);
		cyc(3);
		`CHK("coil", 1'b0, relay_out.coil)
		trip_state_in <= 1'b1;
		cyc(3);
		`CHK("coil", 1'b1, relay_out.coil)
		`CHK("loop", 1'b0, loop_closed)
		trip_state_in <= 1'b0;
		// voltage loss against the start threshold, loss routed to the open collector
		axi_wr(faso_pkg::OFS_START, 32'h0000_0100);
		axi_wr(faso_pkg::OFS_CTRL, 32'h0506_0100);
		faso_ref_model_i.set_ref(12'h0ff, 12'h1f4, 1'b0);
		cyc(2);
		`CHK("loss", 1'b1, analog_loss_flag_out)
		`CHK("oc", 1'b1, open_collector_out)
		`CHK("alarm", 1'b0, fault_alarm_flag_out)
		faso_ref_model_i.set_ref(12'h101, 12'h1f4, 1'b0);
		cyc(2);
		`CHK("loss", 1'b0, analog_loss_flag_out)
		// current input at the floor boundary
		faso_ref_model_i.set_ref(12'h101, 12'h18f, 1'b1);
		cyc(2);
		`CHK("loss", 1'b1, analog_loss_flag_out)
		faso_ref_model_i.set_ref(12'h101, 12'h190, 1'b1);
		cyc(2);
		`CHK("loss", 1'b0, analog_loss_flag_out)
		// lane-1 write clears only the source select: loss is refused then
		s_axi_wstrb <= 4'h2;
		axi_wr(faso_pkg::OFS_CTRL, 32'h0000_0000);
		s_axi_wstrb <= 4'hf;
		axi_rd(faso_pkg::OFS_CTRL);
		`CHK("ctrl", 32'h0506_0000, rd)
		faso_ref_model_i.set_ref(12'h0ff, 12'h190, 1'b0);
		cyc(2);
		`CHK("loss", 1'b0, analog_loss_flag_out)
		`CHK("oc", 1'b0, open_collector_out)
		// unknown open-collector code drives nothing
		axi_wr(faso_pkg::OFS_CTRL, 32'h0500_0101);
		cyc(2);
		`CHK("loss", 1'b1, analog_loss_flag_out)
		`CHK("oc", 1'b0, open_collector_out)
		// every flag edge so far left a sticky event; one write clears them all
		axi_rd(faso_pkg::OFS_IRQ_STAT);
		`CHK("ist", 32'h0000_000f, rd)
		axi_wr(faso_pkg::OFS_IRQ_STAT, 32'h0000_000f);
		axi_rd(faso_pkg::OFS_IRQ_STAT);
		`CHK("ist", 32'h0000_0000, rd)
		// power loss in nc polarity
		axi_wr(faso_pkg::OFS_CTRL, faso_pkg::CTRL_RESET);
		faso_ref_model_i.set_wiring(1'b1);
		cyc(3);
		`CHK("loop", 1'b1, loop_closed)
		rst_n_in <= 1'b0;
		#1;
		`CHK("loop", 1'b0, loop_closed)
		finish_test();
	end
endmodule : testbench
`default_nettype wire
